// ==== hw/dasc_crc_decode.sv ====
// one-hot crc status, zero when crc is off, from synchronised engine flags
module dasc_crc_decode (
    input wire logic crc_enabled_i,
    input wire logic crc_done_i,
    input wire logic crc_fail_i,
    output logic [2:0] code_o
);
    always_comb
    begin
        if (!crc_enabled_i)
            code_o = dasc_pkg::CRC_OFF;
        else if (!crc_done_i)
            code_o = dasc_pkg::CRC_BUSY;
        else if (crc_fail_i)
            code_o = dasc_pkg::CRC_FAIL;
        else
            code_o = dasc_pkg::CRC_OK;
    end
endmodule // dasc_crc_decode

// ==== hw/dasc_pkg.sv ====
package dasc_pkg;
    localparam logic [7:0] ADDR_ACCESS_CONTROL_A = 8'h09;
    localparam logic [7:0] ADDR_SYSTEM_CONTROL_A = 8'h0a;
    localparam logic [7:0] ADDR_SYSTEM_STATUS = 8'h0b;
    localparam logic [7:0] ADDR_CRC_EXECUTION_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_RESET_REQUEST = 8'h08;
    localparam logic [1:0] CLKSEL_RESET = 2'h3;
    localparam logic [1:0] CLKSEL_32MHZ = 2'h0;
    localparam logic [1:0] CLKSEL_16MHZ = 2'h1;
    localparam logic [1:0] CLKSEL_8MHZ = 2'h2;
    localparam logic [1:0] CLKSEL_4MHZ = 2'h3;
    localparam logic [7:0] RESET_SIGNATURE = 8'h59;
    localparam logic [7:0] RESET_RELEASE = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h01;
    localparam int CTRL_CLK_REQUEST_BIT = 0;
    localparam int CTRL_USER_ROW_DONE_BIT = 1;
    localparam int ST_LOCK = 0;
    localparam int ST_BOOT = 1;
    localparam int ST_USER_ROW_START = 2;
    localparam int ST_PROG_START = 3;
    localparam int ST_SLEEP = 4;
    localparam int ST_RESET_ACTIVE = 5;
    localparam int ST_ERASE_FAILED = 6;
    localparam int ST_BOOT_OR_FAIL = 7;
    localparam logic [2:0] CRC_OFF = 3'h0;
    localparam logic [2:0] CRC_BUSY = 3'h1;
    localparam logic [2:0] CRC_OK = 3'h2;
    localparam logic [2:0] CRC_FAIL = 3'h4;
endpackage : dasc_pkg

// ==== hw/dasc_regs.sv ====
module dasc_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic urow_key_ok_i,
    input wire logic sys_in_reset_i,
    input wire logic sys_sleep_i,
    input wire logic erase_fail_i,
    input wire logic boot_done_i,
    input wire logic locked_i,
    input wire logic prog_start_i,
    input wire logic urow_start_i,
    input wire logic crc_enabled_i,
    input wire logic crc_done_i,
    input wire logic crc_fail_i,
    output logic [7:0] rdata_o,
    output logic [1:0] clk_sel_o,
    output logic clk_req_o,
    output logic urow_done_o,
    output logic sys_reset_req_o,
    output logic access_ok_o
);
    ////////////////////////////////////////////////////////////////////////
    logic s_rst;
    logic s_sleep;
    logic s_efail;
    logic s_boot;
    logic s_lock;
    logic s_prog;
    logic s_urow;
    logic s_crc_en;
    logic s_crc_done;
    logic s_crc_fail;
    logic [2:0] crc_code;

    dasc_sync #(.WIDTH(10)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({sys_in_reset_i, sys_sleep_i, erase_fail_i, boot_done_i, locked_i,
              prog_start_i, urow_start_i, crc_enabled_i, crc_done_i, crc_fail_i}),
        .q_o({s_rst, s_sleep, s_efail, s_boot, s_lock, s_prog, s_urow,
              s_crc_en, s_crc_done, s_crc_fail})
    );

    dasc_crc_decode u_crc (
        .crc_enabled_i(s_crc_en),
        .crc_done_i(s_crc_done),
        .crc_fail_i(s_crc_fail),
        .code_o(crc_code)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] clk_sel;
    logic clk_req;
    logic urow_done;
    logic [7:0] rst_req;
    logic efail;
    logic reset_active;
    logic boot;
    logic lock;
    logic enable_q;
    logic [7:0] rdata;
    logic [1:0] next_clk_sel;
    logic next_clk_req;
    logic next_urow_done;
    logic [7:0] next_rst_req;
    logic next_efail;
    logic next_reset_active;
    logic next_boot;
    logic next_lock;
    logic [7:0] next_rdata;
    logic held_reset;
    logic wr_ctrl;
    logic rd_status;
    logic [1:0] settle;
    logic [1:0] next_settle;

    always_comb
    begin
        held_reset = (rst_req == dasc_pkg::RESET_SIGNATURE) || s_rst;
        wr_ctrl = wr_i && (addr_i == dasc_pkg::ADDR_SYSTEM_CONTROL_A);
        rd_status = rd_i && (addr_i == dasc_pkg::ADDR_SYSTEM_STATUS);
        next_clk_sel = clk_sel;
        next_clk_req = clk_req;
        next_urow_done = 1'b0;
        next_rst_req = rst_req;
        if (enable_i && !enable_q)
        begin
            next_clk_sel = dasc_pkg::CLKSEL_RESET;
            next_clk_req = 1'b1;
        end
        else if (wr_i && (addr_i == dasc_pkg::ADDR_ACCESS_CONTROL_A))
            next_clk_sel = wdata_i[1:0];
        else if (wr_ctrl)
        begin
            next_clk_req = wdata_i[dasc_pkg::CTRL_CLK_REQUEST_BIT];
            next_urow_done = wdata_i[dasc_pkg::CTRL_USER_ROW_DONE_BIT] && urow_key_ok_i;
        end
        else if (wr_i && (addr_i == dasc_pkg::ADDR_RESET_REQUEST))
            next_rst_req = wdata_i;
        // failure sets, held reset clears; set wins
        if (s_efail)
            next_efail = 1'b1;
        else if (held_reset)
            next_efail = 1'b0;
        else
            next_efail = efail;
        // reset presence sets, read clears; set wins
        if (held_reset)
            next_reset_active = 1'b1;
        else if (rd_status)
            next_reset_active = 1'b0;
        else
            next_reset_active = reset_active;
        next_boot = held_reset ? 1'b0 : s_boot;
        // lock keeps its reset value until the synchroniser has filled
        next_settle = {settle[0], 1'b1};
        next_lock = settle[1] ? s_lock : lock;
        next_rdata = 8'h00;
        if (rd_i)
        begin
            if (addr_i == dasc_pkg::ADDR_ACCESS_CONTROL_A)
                next_rdata = {6'h00, clk_sel};
            else if (addr_i == dasc_pkg::ADDR_SYSTEM_CONTROL_A)
                next_rdata = {6'h00, urow_done, clk_req};
            else if (addr_i == dasc_pkg::ADDR_RESET_REQUEST)
                next_rdata = rst_req;
            else if (addr_i == dasc_pkg::ADDR_SYSTEM_STATUS)
            begin
                next_rdata[dasc_pkg::ST_BOOT_OR_FAIL] = efail || boot;
                next_rdata[dasc_pkg::ST_ERASE_FAILED] = efail;
                next_rdata[dasc_pkg::ST_RESET_ACTIVE] = reset_active;
                next_rdata[dasc_pkg::ST_SLEEP] = s_sleep;
                next_rdata[dasc_pkg::ST_PROG_START] = s_prog;
                next_rdata[dasc_pkg::ST_USER_ROW_START] = s_urow;
                next_rdata[dasc_pkg::ST_BOOT] = boot;
                next_rdata[dasc_pkg::ST_LOCK] = lock;
            end
            else if (addr_i == dasc_pkg::ADDR_CRC_EXECUTION_STATUS)
                next_rdata = {5'h00, crc_code};
        end
    end

    // status and crc registers have no write path
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clk_sel <= dasc_pkg::CLKSEL_RESET;
            clk_req <= 1'b0;
            urow_done <= 1'b0;
            rst_req <= dasc_pkg::RESET_RELEASE;
            efail <= 1'b0;
            reset_active <= 1'b0;
            settle <= 2'h0;
            boot <= 1'b0;
            lock <= dasc_pkg::STATUS_RESET[dasc_pkg::ST_LOCK];
            enable_q <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            clk_sel <= next_clk_sel;
            clk_req <= next_clk_req;
            urow_done <= next_urow_done;
            rst_req <= next_rst_req;
            efail <= next_efail;
            reset_active <= next_reset_active;
            settle <= next_settle;
            boot <= next_boot;
            lock <= next_lock;
            enable_q <= enable_i;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic next_sys_reset_req;
    logic next_access_ok;

    always_comb
    begin
        next_sys_reset_req = (next_rst_req == dasc_pkg::RESET_SIGNATURE);
        next_access_ok = next_boot && !next_reset_active;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sys_reset_req_o <= 1'b0;
            access_ok_o <= 1'b0;
        end
        else
        begin
            sys_reset_req_o <= next_sys_reset_req;
            access_ok_o <= next_access_ok;
        end
    end

    assign rdata_o = rdata;
    assign clk_sel_o = clk_sel;
    assign clk_req_o = clk_req;
    assign urow_done_o = urow_done;

    ////////////////////////////////////////////////////////////////////////
    property p_clksel_enable;
        @(posedge clk_i) disable iff (rst_i)
        (enable_i && !enable_q) |=> (clk_sel_o == dasc_pkg::CLKSEL_4MHZ);
    endproperty
    a_clksel_enable: assert property (p_clksel_enable) else $error("clk sel not 4 MHz");

    property p_urow_key;
        @(posedge clk_i) disable iff (rst_i)
        urow_done_o |-> $past(urow_key_ok_i) && $past(wr_ctrl);
    endproperty
    a_urow_key: assert property (p_urow_key) else $error("urow done without key");

    property p_urow_start;
        @(posedge clk_i) disable iff (rst_i)
        (wr_ctrl && !(enable_i && !enable_q) && urow_key_ok_i
            && wdata_i[dasc_pkg::CTRL_USER_ROW_DONE_BIT]) |=> urow_done_o;
    endproperty
    a_urow_start: assert property (p_urow_start) else $error("urow done missing");

    property p_system_clock_request_auto;
        @(posedge clk_i) disable iff (rst_i)
        (enable_i && !enable_q) |=> clk_req_o;
    endproperty
    a_system_clock_request_auto: assert property (p_system_clock_request_auto) else $error("clk req not set");

    property p_system_clock_request_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_ctrl && !(enable_i && !enable_q))
            |=> (clk_req_o == $past(wdata_i[dasc_pkg::CTRL_CLK_REQUEST_BIT]));
    endproperty
    a_system_clock_request_write: assert property (p_system_clock_request_write) else $error("clk req write lost");

    property p_boot_or_fail;
        @(posedge clk_i) disable iff (rst_i)
        rd_status |=> (rdata_o[dasc_pkg::ST_BOOT_OR_FAIL]
            == (rdata_o[dasc_pkg::ST_ERASE_FAILED] || rdata_o[dasc_pkg::ST_BOOT]));
    endproperty
    a_boot_or_fail: assert property (p_boot_or_fail) else $error("bit 7 not or");

    property p_reset_active_clear;
        @(posedge clk_i) disable iff (rst_i)
        (rd_status && !held_reset) |=> !reset_active;
    endproperty
    a_reset_active_clear: assert property (p_reset_active_clear) else $error("reset flag kept");

    property p_reset_req;
        @(posedge clk_i) disable iff (rst_i)
        (wr_i && !(enable_i && !enable_q) && addr_i == dasc_pkg::ADDR_RESET_REQUEST
            && wdata_i == dasc_pkg::RESET_SIGNATURE) |=> sys_reset_req_o;
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("reset not requested");

    property p_crc_onehot;
        @(posedge clk_i) disable iff (rst_i)
        rd_i && addr_i == dasc_pkg::ADDR_CRC_EXECUTION_STATUS |=> $onehot0(rdata_o[2:0]);
    endproperty
    a_crc_onehot: assert property (p_crc_onehot) else $error("crc not one-hot");

    property p_efail_set;
        @(posedge clk_i) disable iff (rst_i)
        s_efail |=> efail;
    endproperty
    a_efail_set: assert property (p_efail_set) else $error("erase fail lost");

    property p_lock_after_reset;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |=> lock ##1 lock;
    endproperty
    a_lock_after_reset: assert property (p_lock_after_reset) else $error("lock dropped");

    property p_reset_active_set;
        @(posedge clk_i) disable iff (rst_i)
        s_rst |=> reset_active;
    endproperty
    a_reset_active_set: assert property (p_reset_active_set) else $error("reset flag missing");

    property p_sleep_read;
        @(posedge clk_i) disable iff (rst_i)
        rd_status |=> (rdata_o[dasc_pkg::ST_SLEEP] == $past(s_sleep));
    endproperty
    a_sleep_read: assert property (p_sleep_read) else $error("sleep flag wrong");
endmodule // dasc_regs

// ==== hw/dasc_sync.sv ====
module dasc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb
    begin
        next_meta = d_i;
        next_q = meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule // dasc_sync

// ==== testbench/dasc_dbg_model.sv ====
// debugger side of the register access port
module dasc_dbg_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // single-cycle write strobe, data scrambled once released
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
        addr_o <= ~a;
        #1;
    endtask

    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
endmodule // dasc_dbg_model

// ==== testbench/debug_access_sys_ctrl_status_tb.sv ====
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
        end \
    end

module debug_access_sys_ctrl_status_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i, rst_i, enable_i, key_i, wr_i, rd_i;
    logic [9:0] sv;
    logic [7:0] addr_i, wdata_i, rdata_o, d;
    logic [1:0] clk_sel_o;
    logic clk_req_o, urow_done_o, sys_reset_req_o, access_ok_o;
    int err_total, n_tests;
    // status and crc inputs, register, expected value
    logic [9:0] tv [9] = '{10'h010, 10'h008, 10'h002, 10'h020, 10'h040,
        10'h000, 10'h080, 10'h180, 10'h380};
    logic [7:0] ta [9] = '{8'h0b, 8'h0b, 8'h0b, 8'h0b, 8'h0b, 8'h0c, 8'h0c, 8'h0c, 8'h0c};
    logic [7:0] te [9] = '{8'h01, 8'h82, 8'h10, 8'h08, 8'h04, 8'h00, 8'h01, 8'h02, 8'h04};

    dasc_regs u_dasc_regs (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i),
        .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .urow_key_ok_i(key_i),
        .sys_in_reset_i(sv[0]), .sys_sleep_i(sv[1]), .erase_fail_i(sv[2]),
        .boot_done_i(sv[3]), .locked_i(sv[4]), .prog_start_i(sv[5]), .urow_start_i(sv[6]),
        .crc_enabled_i(sv[7]), .crc_done_i(sv[8]), .crc_fail_i(sv[9]), .rdata_o(rdata_o),
        .clk_sel_o(clk_sel_o), .clk_req_o(clk_req_o), .urow_done_o(urow_done_o),
        .sys_reset_req_o(sys_reset_req_o), .access_ok_o(access_ok_o));

    dasc_dbg_model u_dasc_dbg_model (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
        .wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic setin(input logic [9:0] v);
        @(posedge clk_i);
        sv <= v;
        repeat (5) @(posedge clk_i);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_dasc_dbg_model.get(a, d);
        `CHK("rdata", e, d)
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        err_total = 0;
        n_tests = 0;
        rst_i = 1'b1;
        enable_i = 1'b0;
        key_i = 1'b0;
        sv = 10'h010;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(8'h0b, 8'h01);
        rchk(8'h0c, 8'h00);
        rchk(8'h09, 8'h03);
        `CHK("clk_req", 1'b0, clk_req_o)
        for (int c = 0; c < 4; c++)
        begin
            u_dasc_dbg_model.put(8'h09, 8'(3 - c));
            `CHK("clk_sel", 2'(3 - c), clk_sel_o)
        end
        @(posedge clk_i);
        enable_i <= 1'b1;
        @(posedge clk_i);
        #1;
        `CHK("clk_req", 1'b1, clk_req_o)
        `CHK("clk_sel", 2'h3, clk_sel_o)
        u_dasc_dbg_model.put(8'h0a, 8'h00);
        `CHK("clk_req", 1'b0, clk_req_o)
        u_dasc_dbg_model.put(8'h0a, 8'h02);
        `CHK("urow_done", 1'b0, urow_done_o)
        @(posedge clk_i);
        key_i <= 1'b1;
        u_dasc_dbg_model.put(8'h0a, 8'h03);
        `CHK("urow_done", 1'b1, urow_done_o)
        `CHK("clk_req", 1'b1, clk_req_o)
        @(posedge clk_i);
        #1;
        `CHK("urow_done", 1'b0, urow_done_o)
        u_dasc_dbg_model.put(8'h07, 8'h20);
        @(posedge clk_i);
        key_i <= 1'b0;
        u_dasc_dbg_model.put(8'h0a, 8'h03);
        `CHK("urow_done", 1'b0, urow_done_o)
        for (int i = 0; i < 9; i++)
        begin
            setin(tv[i]);
            rchk(ta[i], te[i]);
            if (i == 1)
                `CHK("access", 1'b1, access_ok_o)
        end
        u_dasc_dbg_model.put(8'h0b, 8'hff);
        u_dasc_dbg_model.put(8'h0c, 8'hff);
        rchk(8'h0b, 8'h00);
        rchk(8'h0c, 8'h04);
        setin(10'h00c);
        rchk(8'h0b, 8'hc2);
        setin(10'h008);
        rchk(8'h0b, 8'hc2);
        u_dasc_dbg_model.put(8'h08, 8'h59);
        `CHK("sys_reset_req", 1'b1, sys_reset_req_o)
        setin(10'h008);
        rchk(8'h0b, 8'h20);
        `CHK("access", 1'b0, access_ok_o)
        u_dasc_dbg_model.put(8'h08, 8'h00);
        `CHK("sys_reset_req", 1'b0, sys_reset_req_o)
        setin(10'h008);
        rchk(8'h0b, 8'ha2);
        rchk(8'h0b, 8'h82);
        setin(10'h001);
        rchk(8'h0b, 8'h20);
        setin(10'h000);
        rchk(8'h0b, 8'h20);
        rchk(8'h0b, 8'h00);
        rchk(8'h20, 8'h00);
        finish_test();
    end
endmodule // debug_access_sys_ctrl_status_tb
